// ==== scl_host.sv ====
// Host side of the three-wire port; lines change only on falling system edges
module scl_host (
    input wire logic clk_i,
    output logic sclk_o,
    output logic data_o,
    output logic le_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle low from time zero
    initial begin
        sclk_o = 1'b0;
        data_o = 1'b0;
        le_o = 1'b0;
    end
    // Three cycles per level so every edge is seen
    task automatic hold();
        repeat (3) @(negedge clk_i);
    endtask
    // Shift n bits, msb first, so the address goes last
    task automatic shift(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            data_o = w[i];
            hold();
            sclk_o = 1'b1;
            hold();
            // Data moves with the falling clock, well clear of the sampled rise
            sclk_o = 1'b0;
        end
        data_o = 1'b0;
    endtask
    // Latch pulse, optionally with extra clocks while it stays high
    task automatic latch(input int extra);
        le_o = 1'b1;
        hold();
        shift(32'h0000_0000, extra);
        le_o = 1'b0;
        hold();
    endtask
endmodule

// ==== scl_loader.sv ====
module scl_loader (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic serial_prog_clock_i,
    input wire logic serial_prog_data_i,
    input wire logic serial_prog_latch_enable_i,
    input wire logic [scl_pkg::ADDR_W-1:0] cfg_rd_addr_i,
    output logic [scl_pkg::WORD_W-1:0] cfg_rd_data_o,
    output logic cfg_wr_o,
    output logic [scl_pkg::ADDR_W-1:0] cfg_wr_addr_o,
    output logic [scl_pkg::WORD_W-1:0] cfg_wr_data_o,
    output logic align_event_o,
    output logic pending_o
);
    // Edge flags of the serial clock and latch lines
    logic sclk_rise;
    logic le_rise;
    logic le_fall;
    // Programming shift register
    logic [scl_pkg::WORD_W-1:0] shift_reg;
    // Configuration register file
    logic [scl_pkg::WORD_W-1:0] cfg_mem [scl_pkg::REG_COUNT];
    // Large value waiting for its commit sequence
    logic [scl_pkg::WORD_W-1:0] pend_word;
    logic [1:0] extra_cnt;
    // Decode of the word now in the shift register
    logic [scl_pkg::ADDR_W-1:0] word_addr;
    logic word_large;
    logic double_hit;
    logic extra_done;

    scl_edge u_clk_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(serial_prog_clock_i),
        .rise_o(sclk_rise),
        .fall_o()
    );

    scl_edge u_le_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(serial_prog_latch_enable_i),
        .rise_o(le_rise),
        .fall_o(le_fall)
    );

    // Address from the trailing bits, large-value test on the fields
    always_comb begin
        word_addr = shift_reg[scl_pkg::ADDR_W-1:0];
        word_large = (word_addr <= scl_pkg::GROUP_REG_LAST) &&
            ((shift_reg[scl_pkg::DIV_LSB +: scl_pkg::DIV_W] > scl_pkg::DIV_LARGE_ABOVE) ||
             (shift_reg[scl_pkg::DLY_LSB +: scl_pkg::DLY_W] > scl_pkg::DLY_LARGE_ABOVE));
        // Repeat of the last large word is taken at once, even if the clocks of
        // the repeat already committed the armed copy; otherwise it would re-arm
        double_hit = (pend_word == shift_reg);
        extra_done = pending_o && sclk_rise && (extra_cnt == scl_pkg::EXTRA_CLOCKS - 2'h1);
    end

    // Shifting never stops, readback included; host keeps it harmless
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[scl_pkg::WORD_W-2:0], serial_prog_data_i};
        end
    end

    // Pending large value: committed by three extra clocks or a rewrite
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_o <= 1'b0;
            pend_word <= '0;
            extra_cnt <= 2'h0;
        end else if (le_rise && word_large && !double_hit) begin
            // First load of a large value only arms the commit
            pending_o <= 1'b1;
            pend_word <= shift_reg;
            extra_cnt <= 2'h0;
        end else if ((le_rise && double_hit) || extra_done) begin
            pending_o <= 1'b0;
            extra_cnt <= 2'h0;
        end else if (pending_o && sclk_rise) begin
            // Clocks count whether latch is high or low
            extra_cnt <= extra_cnt + 2'h1;
        end
    end

    // Write strobe toward the register file
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_wr_o <= 1'b0;
            cfg_wr_addr_o <= '0;
            cfg_wr_data_o <= '0;
        end else if (le_rise && (!word_large || double_hit)) begin
            // Plain word, or second identical write of a large one
            cfg_wr_o <= 1'b1;
            cfg_wr_addr_o <= word_addr;
            cfg_wr_data_o <= shift_reg;
        end else if (extra_done) begin
            // Third extra clock commits the armed word
            cfg_wr_o <= 1'b1;
            cfg_wr_addr_o <= pend_word[scl_pkg::ADDR_W-1:0];
            cfg_wr_data_o <= pend_word;
        end else begin
            cfg_wr_o <= 1'b0;
        end
    end

    // Register file; no reset so it maps to plain storage
    always_ff @(posedge clk_i) begin
        if (cfg_wr_o) begin
            cfg_mem[cfg_wr_addr_o] <= cfg_wr_data_o;
        end
    end

    // Read port, one clock of latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rd_data_o <= '0;
        end else begin
            cfg_rd_data_o <= cfg_mem[cfg_rd_addr_i];
        end
    end

    // Enable bit tracked in a flop so reset leaves it defined
    logic align_en;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            align_en <= 1'b0;
        end else if (cfg_wr_o && cfg_wr_addr_o == scl_pkg::ALIGN_REG) begin
            align_en <= cfg_wr_data_o[scl_pkg::ALIGN_BIT];
        end
    end

    // Alignment pulse on latch fall when enabled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            align_event_o <= 1'b0;
        end else begin
            align_event_o <= le_fall && align_en;
        end
    end

    a_shift_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sclk_rise |=> shift_reg[0] == $past(serial_prog_data_i))
        else $error("data bit not shifted in");
    a_shift_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !sclk_rise |=> $stable(shift_reg))
        else $error("shift register moved without clock");
    a_plain_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (le_rise && !word_large) |=> cfg_wr_o && cfg_wr_data_o == $past(shift_reg))
        else $error("plain word not written");
    a_addr_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        le_rise && !word_large |=> cfg_wr_addr_o == $past(shift_reg[scl_pkg::ADDR_W-1:0]))
        else $error("wrong decoded address");
    a_large_arm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (le_rise && word_large && !double_hit) |=> pending_o && !cfg_wr_o)
        else $error("large value written without sequence");
    a_double_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (le_rise && double_hit) |=> cfg_wr_o && !pending_o)
        else $error("double write not committed");
    a_extra_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        extra_done |=> cfg_wr_o && cfg_wr_data_o == $past(pend_word))
        else $error("extra clocks did not commit");
    a_align_event: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        align_event_o |-> $past(le_fall) && $past(align_en))
        else $error("alignment event without cause");
    a_align_miss: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (le_fall && align_en) |=> align_event_o)
        else $error("alignment event missed");
    a_wr_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_wr_o |-> $past(le_rise) || $past(extra_done))
        else $error("write without latch or commit");

    c_plain: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        le_rise && !word_large);
    c_double: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        le_rise && double_hit);
    c_extra: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        extra_done && serial_prog_latch_enable_i);
    c_align: cover property (@(posedge clk_i) disable iff (!rst_n_i) align_event_o);
endmodule

// ==== scl_pkg.sv ====
package scl_pkg;
    // Word and address geometry
    localparam int WORD_W = 32;
    localparam int ADDR_W = 5;
    localparam int REG_COUNT = 32;
    // Registers that hold the output-group divide and digital delay
    localparam logic [4:0] GROUP_REG_LAST = 5'h05;
    // Divide value field inside a group register word
    localparam int DIV_LSB = 5;
    localparam int DIV_W = 11;
    // Digital delay field inside a group register word
    localparam int DLY_LSB = 16;
    localparam int DLY_W = 10;
    // Values above these need the extra-clock or double-write sequence
    localparam logic [10:0] DIV_LARGE_ABOVE = 11'h019;
    localparam logic [9:0] DLY_LARGE_ABOVE = 10'h00c;
    // Extra serial clocks that commit a pending large value
    localparam logic [1:0] EXTRA_CLOCKS = 2'h3;
    // Location of the automatic alignment enable bit
    localparam logic [4:0] ALIGN_REG = 5'h0b;
    localparam int ALIGN_BIT = 24;
endpackage

module scl_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    // Previous sample of the line
    logic prev;

    // Line is already synchronous, so one stage suffices
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= level_i;
        end
    end

    // Edge flags last one clock
    assign rise_o = level_i & ~prev;
    assign fall_o = ~level_i & prev;
endmodule

// ==== test_serial_config_loader.sv ====
module test_serial_config_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk, sdat, sle, wr, align, pend;
    logic [4:0] rd_addr = 5'h00;
    logic [4:0] wr_addr;
    logic [31:0] rd_data, wr_data;
    int errors = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    int al_cnt = 0;
    // 125 MHz system clock
    always #4 clk_i = ~clk_i;
    // Count one-cycle pulses as they happen
    always @(posedge clk_i) begin
        if (wr === 1'b1) wr_cnt++;
        if (align === 1'b1) al_cnt++;
    end
    scl_host i_scl_host (.clk_i(clk_i), .sclk_o(sclk), .data_o(sdat), .le_o(sle));
    scl_loader i_scl_loader (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .serial_prog_clock_i(sclk), .serial_prog_data_i(sdat),
        .serial_prog_latch_enable_i(sle), .cfg_rd_addr_i(rd_addr),
        .cfg_rd_data_o(rd_data), .cfg_wr_o(wr), .cfg_wr_addr_o(wr_addr),
        .cfg_wr_data_o(wr_data), .align_event_o(align), .pending_o(pend));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One framed word, then a latch pulse, then the write count
    task automatic put(input logic [31:0] w, input int extra, input int dw);
        int c0;
        c0 = wr_cnt;
        i_scl_host.shift(w, 32);
        i_scl_host.latch(extra);
        check(32'(wr_cnt - c0), 32'(dw));
    endtask
    // Plain write, then read the register file back
    task automatic s_plain();
        put(32'ha5c3_3c67, 0, 1);
        check({27'h0, wr_addr}, 32'h0000_0007);
        check(wr_data, 32'ha5c3_3c67);
        rd_addr = 5'h07;
        repeat (2) @(negedge clk_i);
        check(rd_data, 32'ha5c3_3c67);
    endtask
    // Divide at the threshold passes; one above needs extra clocks
    task automatic s_extra();
        int c0;
        put(32'h0000_0321, 0, 1);
        put(32'h0000_0342, 0, 0);
        check({31'h0, pend}, 32'h0000_0001);
        // Three bare clocks with latch low commit the armed word
        c0 = wr_cnt;
        i_scl_host.shift(32'h0000_0000, 3);
        check(32'(wr_cnt - c0), 32'h0000_0001);
        check({31'h0, pend}, 32'h0000_0000);
        check(wr_data, 32'h0000_0342);
        // Another large divide, extra clocks given with latch held high
        put(32'h0000_0363, 3, 1);
        check({31'h0, pend}, 32'h0000_0000);
        check(wr_data, 32'h0000_0363);
    endtask
    // Large delay committed by writing the same word twice
    task automatic s_double();
        put(32'h000d_0004, 0, 0);
        // Repeat: its first clocks commit the armed copy, its latch writes again
        put(32'h000d_0004, 0, 2);
        check({31'h0, pend}, 32'h0000_0000);
        check(wr_data, 32'h000d_0004);
    endtask
    // Alignment on each latch fall only while enabled
    task automatic s_align();
        int a0;
        a0 = al_cnt;
        put(32'h0100_000b, 0, 1);
        put(32'h0000_0027, 0, 1);
        check(32'(al_cnt - a0), 32'h0000_0002);
        put(32'h0000_000b, 0, 1);
        a0 = al_cnt;
        put(32'h0000_0027, 0, 1);
        check(32'(al_cnt - a0), 32'h0000_0000);
    endtask
    task automatic conclude();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        s_plain();
        s_extra();
        s_double();
        s_align();
        conclude();
    end
endmodule
